//--- hrps_pkg.sv
// Shared constants for the host register port and statistics latch.
`default_nettype none
package hrps_pkg;
  // Byte-wide register data
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_GENERAL = 8'h00;
  localparam logic [7:0] OFS_OUT_PIN = 8'h02;
  localparam logic [7:0] OFS_PART_ID = 8'h03;
  localparam logic [7:0] OFS_LIVE_STAT = 8'h04;
  localparam logic [7:0] OFS_EVT_STAT = 8'h05;
  localparam logic [7:0] OFS_CNT_BASE = 8'h08;
  // Field positions in general_control
  localparam int BIT_SOFT_RST = 0;
  localparam int BIT_STAT_PIN_MODE = 2;
  localparam int BIT_CNT_LATCH = 4;
  localparam int BIT_STAT_LATCH = 5;
  localparam int BIT_IRQ_PIN = 6;
  // Bits of general_control that hold a stored value
  localparam logic [7:0] GENERAL_MASK = 8'h74;
  // Values after reset, and the value read from unmapped offsets
  localparam logic [7:0] GENERAL_RESET = 8'h00;
  localparam logic [7:0] OUT_PIN_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Counter geometry: two bytes, low byte at the even offset
  localparam int CNT_W = 16;
  localparam int CNT_BYTES = 2;
  // Reference periods per second pulse
  localparam int REF_PERIODS_DEFAULT = 8000;
endpackage
`default_nettype wire

//--- hrps_host_port.sv
// Host register port with one-second statistics latching.
// How it works
// - Every host access moves exactly one byte.
// - Mode pin picks asynchronous or synchronous port.
// - Async transfers qualified by select and strobes.
// - Speed pin picks fast or low-power async.
// - Sync port samples pins on host clock.
// - Live status plus sticky event status bits.
// - Soft reset bit restores all registers.
// - Status pin mode drives pin value register.
// - Fixed read-only part and revision code.
// - Low byte read freezes upper counter bytes.
// - Counters saturate and clear after read.
// - Status latch returns one-second snapshot.
// - Counter latch returns one-second snapshot.
// - At capture, counters move to latch, clear.
// - Second pulse one ref period per 8000.
// - Interrupt pin gated by enable bit.
`default_nettype none
module hrps_host_port #(
  parameter int ADDR_W = 8,
  parameter int NUM_CNT = 2,
  parameter int REF_PERIODS = hrps_pkg::REF_PERIODS_DEFAULT,
  parameter logic [7:0] PART_ID = 8'h5a  // Arbitrary identification value
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic host_clk_in,
  input wire logic port_mode_select_in,
  input wire logic access_speed_select_in,
  input wire logic host_chip_select_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic host_write_strobe_n_in,
  input wire logic host_write_not_read_in,
  input wire logic host_addr_strobe_n_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [hrps_pkg::DATA_W-1:0] host_data_in,
  output logic [hrps_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe_n_out,
  output logic host_interrupt_n_out,
  input wire logic irq_request_in,
  output logic [7:0] output_status_pins_out,
  input wire logic [7:0] live_status_in,
  input wire logic [7:0] event_status_in,
  input wire logic [NUM_CNT-1:0] count_event_in,
  input wire logic frame_rate_ref_in,
  output logic second_pulse_out,
  input wire logic second_pulse_in
);
  import hrps_pkg::*;

  localparam int RW = $clog2(REF_PERIODS);
  localparam logic [RW-1:0] REF_LAST = RW'(REF_PERIODS - 1);
  // Synchroniser vector: cs, rd, wr, wnr, mode, speed, ref, sec, tgl, addr, data
  localparam int SW = 9 + ADDR_W + DATA_W;
  // Strobes idle high so reset never looks like an access
  localparam logic [SW-1:0] SYNC_RST = {4'hf, {(SW-4){1'b0}}};
  localparam logic [ADDR_W-1:0] CNT_END = ADDR_W'(OFS_CNT_BASE) + ADDR_W'(CNT_BYTES * NUM_CNT);

  // Host clock domain capture of synchronous requests
  logic [ADDR_W-1:0] hreq_addr_reg;  // Held until the next request
  logic [DATA_W-1:0] hreq_data_reg;
  logic hreq_wr_reg;
  logic hreq_tgl_reg;  // Toggles once per request

  // Core side synchroniser stages
  logic [SW-1:0] pin_s1_reg;  // First stage, read only by second stage
  logic [SW-1:0] pin_s2_reg;
  logic cs_n_s, rd_n_s, wr_n_s, wnr_s, mode_s, speed_s, ref_s, sec_s, tgl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  // Edge history
  logic rd_act_d_reg, wr_act_d_reg, ref_d_reg, sec_d_reg, tgl_d_reg;
  logic [ADDR_W-1:0] addr_hold_reg;  // Address seen while a strobe is active
  logic [DATA_W-1:0] wdat_hold_reg;  // Write data seen while the strobe is active

  // Register state
  logic soft_rst_reg;
  logic [7:0] gen_reg;
  logic [7:0] out_pin_reg;
  logic [7:0] evt_reg;
  logic [7:0] snap_live_reg;
  logic [7:0] snap_evt_reg;
  logic [RW-1:0] ref_cnt_reg;
  logic [CNT_W-1:0] cnt_reg [NUM_CNT];
  logic [CNT_W-1:0] latch_reg [NUM_CNT];
  logic [CNT_W-9:0] hold_reg [NUM_CNT];
  logic oe_n_next;

  // Decoded access
  logic rd_act, wr_act, acc_rd, acc_wr, sync_req, sec_cap;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [7:0] rd_val;
  logic cnt_hit;
  logic [ADDR_W-1:0] cnt_off;
  logic stat_latch_en, cnt_latch_en;

  // Synchronous port: pins belong to the host clock, so no synchroniser here
  always_ff @(posedge host_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hreq_addr_reg <= '0;
      hreq_data_reg <= '0;
      hreq_wr_reg <= 1'b0;
      hreq_tgl_reg <= 1'b0;
    end else if (!host_chip_select_n_in && !host_addr_strobe_n_in) begin
      hreq_addr_reg <= host_addr_in;
      hreq_data_reg <= host_data_in;
      hreq_wr_reg <= host_write_not_read_in;
      hreq_tgl_reg <= ~hreq_tgl_reg;
    end
  end

  // Two flip-flops for the port, reference and second-pulse input pins except the address strobe, and for the request toggle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_reg <= SYNC_RST;
      pin_s2_reg <= SYNC_RST;
    end else begin
      pin_s1_reg <= {host_chip_select_n_in, host_read_strobe_n_in, host_write_strobe_n_in,
                     host_write_not_read_in, port_mode_select_in, access_speed_select_in,
                     frame_rate_ref_in, second_pulse_in, hreq_tgl_reg, host_addr_in,
                     host_data_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, wnr_s, mode_s, speed_s, ref_s, sec_s, tgl_s, addr_s,
          data_s} = pin_s2_reg;

  // Strobe qualification for the asynchronous port
  assign rd_act = !mode_s && !cs_n_s && !rd_n_s;
  assign wr_act = !mode_s && !cs_n_s && !wr_n_s;
  // Held address and data are stable by the time a request is seen
  assign sync_req = mode_s && (tgl_s != tgl_d_reg);
  assign sec_cap = sec_s && !sec_d_reg;
  assign stat_latch_en = gen_reg[BIT_STAT_LATCH];
  assign cnt_latch_en = gen_reg[BIT_CNT_LATCH];

  // Edge history and hold registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_act_d_reg <= 1'b0;
      wr_act_d_reg <= 1'b0;
      ref_d_reg <= 1'b0;
      sec_d_reg <= 1'b0;
      tgl_d_reg <= 1'b0;
      addr_hold_reg <= '0;
      wdat_hold_reg <= '0;
    end else begin
      rd_act_d_reg <= rd_act;
      wr_act_d_reg <= wr_act;
      ref_d_reg <= ref_s;
      sec_d_reg <= sec_s;
      tgl_d_reg <= tgl_s;
      if (rd_act || wr_act) begin
        addr_hold_reg <= addr_s;
      end
      if (wr_act) begin
        wdat_hold_reg <= data_s;
      end
    end
  end

  // One access source per mode; fast writes commit at the leading edge
  always_comb begin
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_addr = addr_s;
    acc_wdata = data_s;
    if (sync_req) begin
      acc_rd = !hreq_wr_reg;
      acc_wr = hreq_wr_reg;
      acc_addr = hreq_addr_reg;
      acc_wdata = hreq_data_reg;
    end else if (rd_act && !rd_act_d_reg) begin
      acc_rd = 1'b1;
    end else if (speed_s && wr_act && !wr_act_d_reg) begin
      acc_wr = 1'b1;
    end else if (!speed_s && wr_act_d_reg && !wr_act) begin
      acc_wr = 1'b1;
      acc_addr = addr_hold_reg;
      acc_wdata = wdat_hold_reg;
    end
  end

  // Counter window decode
  assign cnt_off = acc_addr - ADDR_W'(OFS_CNT_BASE);
  assign cnt_hit = (acc_addr >= ADDR_W'(OFS_CNT_BASE)) && (acc_addr < CNT_END);

  // Read data mux
  always_comb begin
    rd_val = RD_UNMAPPED;
    if (acc_addr == ADDR_W'(OFS_GENERAL)) begin
      rd_val = gen_reg | {7'h00, soft_rst_reg};
    end else if (acc_addr == ADDR_W'(OFS_OUT_PIN)) begin
      rd_val = out_pin_reg;
    end else if (acc_addr == ADDR_W'(OFS_PART_ID)) begin
      rd_val = PART_ID;
    end else if (acc_addr == ADDR_W'(OFS_LIVE_STAT)) begin
      rd_val = stat_latch_en ? snap_live_reg : live_status_in;
    end else if (acc_addr == ADDR_W'(OFS_EVT_STAT)) begin
      rd_val = stat_latch_en ? snap_evt_reg : evt_reg;
    end else if (cnt_hit) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (cnt_off[ADDR_W-1:1] == (ADDR_W-1)'(i)) begin
          if (!cnt_off[0]) begin
            rd_val = cnt_latch_en ? latch_reg[i][7:0] : cnt_reg[i][7:0];
          end else begin
            rd_val = hold_reg[i];
          end
        end
      end
    end
  end

  // Soft reset pulse, cleared on the following edge
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_rst_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      soft_rst_reg <= 1'b0;
    end else if (acc_wr && acc_addr == ADDR_W'(OFS_GENERAL)) begin
      soft_rst_reg <= acc_wdata[BIT_SOFT_RST];
    end
  end

  // Control registers written by the host
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gen_reg <= GENERAL_RESET;
      out_pin_reg <= OUT_PIN_RESET;
    end else if (soft_rst_reg) begin
      gen_reg <= GENERAL_RESET;
      out_pin_reg <= OUT_PIN_RESET;
    end else if (acc_wr) begin
      if (acc_addr == ADDR_W'(OFS_GENERAL)) begin
        gen_reg <= acc_wdata & GENERAL_MASK;
      end else if (acc_addr == ADDR_W'(OFS_OUT_PIN)) begin
        out_pin_reg <= acc_wdata;
      end
    end
  end

  // Sticky event status; a new event wins over the read and capture clears, but soft reset clears it too
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      evt_reg <= 8'h00;
      snap_live_reg <= 8'h00;
      snap_evt_reg <= 8'h00;
    end else if (soft_rst_reg) begin
      evt_reg <= 8'h00;
      snap_live_reg <= 8'h00;
      snap_evt_reg <= 8'h00;
    end else if (sec_cap && stat_latch_en) begin
      snap_live_reg <= live_status_in;
      snap_evt_reg <= evt_reg | event_status_in;
      evt_reg <= event_status_in;
    end else if (acc_rd && acc_addr == ADDR_W'(OFS_EVT_STAT) && !stat_latch_en) begin
      evt_reg <= event_status_in;
    end else begin
      evt_reg <= evt_reg | event_status_in;
    end
  end

  // Event counters, one set of registers per counter
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    logic lsb_rd;
    assign lsb_rd = acc_rd && cnt_hit && !cnt_off[0] &&
                    (cnt_off[ADDR_W-1:1] == (ADDR_W-1)'(g));

    // Live count saturates rather than wrapping into a false small value
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        cnt_reg[g] <= '0;
      end else if (soft_rst_reg) begin
        cnt_reg[g] <= '0;
      end else if ((sec_cap && cnt_latch_en) || (lsb_rd && !cnt_latch_en)) begin
        cnt_reg[g] <= {{(CNT_W-1){1'b0}}, count_event_in[g]};
      end else if (count_event_in[g] && cnt_reg[g] != {CNT_W{1'b1}}) begin
        cnt_reg[g] <= cnt_reg[g] + 1'b1;
      end
    end

    // One-second holding latch
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        latch_reg[g] <= '0;
      end else if (soft_rst_reg) begin
        latch_reg[g] <= '0;
      end else if (sec_cap && cnt_latch_en) begin
        latch_reg[g] <= cnt_reg[g];
      end
    end

    // Upper byte frozen by the low byte read
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        hold_reg[g] <= '0;
      end else if (soft_rst_reg) begin
        hold_reg[g] <= '0;
      end else if (lsb_rd) begin
        hold_reg[g] <= cnt_latch_en ? latch_reg[g][CNT_W-1:8] : cnt_reg[g][CNT_W-1:8];
      end
    end
  end

  // Data bus driver release condition per mode
  always_comb begin
    oe_n_next = host_data_oe_n_out;
    if (acc_rd) begin
      oe_n_next = 1'b0;
    end else if (mode_s ? (cs_n_s || wnr_s) : !rd_act) begin
      oe_n_next = 1'b1;
    end
  end

  // Read data and bus enable
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      host_data_out <= 8'h00;
      host_data_oe_n_out <= 1'b1;
    end else begin
      if (acc_rd) begin
        host_data_out <= rd_val;
      end
      host_data_oe_n_out <= oe_n_next;
    end
  end

  // One-second divider on the frame reference
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ref_cnt_reg <= '0;
      second_pulse_out <= 1'b0;
    end else if (soft_rst_reg) begin
      ref_cnt_reg <= '0;
      second_pulse_out <= 1'b0;
    end else if (ref_s && !ref_d_reg) begin
      if (ref_cnt_reg == REF_LAST) begin
        ref_cnt_reg <= '0;
        second_pulse_out <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 1'b1;
        second_pulse_out <= 1'b0;
      end
    end
  end

  // Pin outputs: status pins and gated interrupt
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_status_pins_out <= 8'h00;
      host_interrupt_n_out <= 1'b1;
    end else begin
      output_status_pins_out <= gen_reg[BIT_STAT_PIN_MODE] ? out_pin_reg
                                                            : live_status_in;
      host_interrupt_n_out <= !(irq_request_in && gen_reg[BIT_IRQ_PIN]);
    end
  end
endmodule
`default_nettype wire

//--- hrps_props.sv
// Port timing checker for the host register port, bound to the top module.
`default_nettype none
module hrps_props #(
  parameter int REF_PERIODS = 8,
  parameter int REF_CYC = 16  // Core cycles per reference period in the bench
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic host_clk_in,
  input wire logic port_mode_select_in,
  input wire logic host_chip_select_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic host_write_not_read_in,
  input wire logic host_addr_strobe_n_in,
  input wire logic irq_request_in,
  input wire logic [hrps_pkg::DATA_W-1:0] host_data_out,
  input wire logic host_data_oe_n_out,
  input wire logic host_interrupt_n_out,
  input wire logic second_pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import hrps_pkg::*;
  logic [7:0] hi_cnt;  // Cycles the second pulse has stood high
  logic [11:0] gap_cnt;  // Cycles since the pulse last rose
  logic seen;  // A first rise has passed, so the gap is meaningful
  logic prev;  // Pulse level one cycle back
  // Pulse length and spacing counters
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_cnt <= 8'h00;
      gap_cnt <= 12'h000;
      seen <= 1'b0;
      prev <= 1'b0;
    end else begin
      hi_cnt <= second_pulse_out ? hi_cnt + 8'h01 : 8'h00;
      gap_cnt <= (second_pulse_out && !prev) ? 12'h001 : gap_cnt + 12'h001;
      seen <= seen | (second_pulse_out && !prev);
      prev <= second_pulse_out;
    end
  end
  rst_vals_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $rose(resetn_in) |-> host_data_oe_n_out && host_interrupt_n_out && !second_pulse_out
    && host_data_out == 8'h00) else $error("outputs not idle after reset");
  irq_off_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !$past(irq_request_in) |-> host_interrupt_n_out) else $error("interrupt without request");
  pulse_len_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $fell(second_pulse_out) |-> hi_cnt == REF_CYC) else $error("second pulse length wrong");
  pulse_gap_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $rose(second_pulse_out) && seen |-> gap_cnt == REF_PERIODS * REF_CYC)
    else $error("second pulse spacing wrong");
  rd_drive_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    $fell(host_data_oe_n_out) && !port_mode_select_in |-> !$past(host_read_strobe_n_in, 2)
    && !$past(host_chip_select_n_in, 2)) else $error("bus driven without read strobe");
  cs_release_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    host_chip_select_n_in [*4] |-> host_data_oe_n_out) else $error("bus driven while idle");
  sync_rd_a: assert property (@(posedge host_clk_in) disable iff (!resetn_in)
    port_mode_select_in && !host_chip_select_n_in && !host_addr_strobe_n_in
    && !host_write_not_read_in |=> !host_data_oe_n_out) else $error("sync read not answered");
  sync_wr_a: assert property (@(posedge host_clk_in) disable iff (!resetn_in)
    port_mode_select_in && !host_chip_select_n_in && !host_addr_strobe_n_in
    && host_write_not_read_in |=> host_data_oe_n_out) else $error("bus driven on sync write");
  sync_rd_c: cover property (@(posedge host_clk_in) port_mode_select_in
    && !host_addr_strobe_n_in && !host_write_not_read_in);
  async_rd_c: cover property (@(posedge core_clk_in) $fell(host_data_oe_n_out));
  pulse_c: cover property (@(posedge core_clk_in) seen && $rose(second_pulse_out));
endmodule
bind hrps_host_port hrps_props #(.REF_PERIODS(REF_PERIODS)) hrps_props_i (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .host_clk_in(host_clk_in),
  .port_mode_select_in(port_mode_select_in), .host_chip_select_n_in(host_chip_select_n_in),
  .host_read_strobe_n_in(host_read_strobe_n_in), .irq_request_in(irq_request_in),
  .host_write_not_read_in(host_write_not_read_in), .host_data_out(host_data_out),
  .host_addr_strobe_n_in(host_addr_strobe_n_in), .host_data_oe_n_out(host_data_oe_n_out),
  .host_interrupt_n_out(host_interrupt_n_out), .second_pulse_out(second_pulse_out));
`default_nettype wire

//--- hrps_host_model.sv
// Host processor model that drives the register port pins.
`default_nettype none
module hrps_host_model (
  input wire logic core_clk_in,
  input wire logic [7:0] dev_data_in,
  output logic host_clk_out,
  output logic mode_out,
  output logic speed_out,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic wnr_out,
  output logic as_n_out,
  output logic [7:0] addr_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running host clock, offset so its edges never meet core edges
  initial begin
    host_clk_out = 1'b0;
    #13;
    forever #40 host_clk_out = ~host_clk_out;
  end
  // Idle pins at time zero
  initial begin
    {mode_out, speed_out, wnr_out} = 3'b010;
    {cs_n_out, rd_n_out, wr_n_out, as_n_out} = 4'hf;
    addr_out = 8'h00;
    data_out = 8'hff;
  end
  // One byte per access; m is 0 async fast, 1 async low power, 2 sync
  task automatic acc(input logic [1:0] m, input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_in);
    mode_out = m[1];
    speed_out = !m[0];
    repeat (4) @(negedge core_clk_in);
    if (m[1]) begin
      @(negedge host_clk_out);
      {cs_n_out, as_n_out, wnr_out} = {2'b00, w};
      addr_out = a;
      data_out = w ? d : ~data_out;
      @(negedge host_clk_out);
      as_n_out = 1'b1;  // Address strobe lasts one host clock
      @(posedge host_clk_out);
      q = dev_data_in;
      @(negedge host_clk_out);
      cs_n_out = 1'b1;
      repeat (2) @(negedge host_clk_out);
    end else begin
      cs_n_out = 1'b0;
      addr_out = a;
      data_out = w ? d : ~data_out;
      rd_n_out = w;
      wr_n_out = !w;
      repeat (6) @(negedge core_clk_in);
      q = dev_data_in;
      {cs_n_out, rd_n_out, wr_n_out} = 3'b111;
      repeat (6) @(negedge core_clk_in);
    end
    data_out = ~data_out;  // Released bus keeps no stale value
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the host register port and statistics latch.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hrps_pkg::*;
  localparam logic [7:0] ID_CODE = 8'hc3;  // Arbitrary identification value
  // Row: mode, offset, write value, read-back, status pins, interrupt pin
  typedef struct packed {
    logic [1:0] m;
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic [7:0] p;
    logic q;
  } hrps_row_t;
  logic clk, rstn, irq, ref_on, ref_clk, sec_in, oe_n, int_n, sec_out;
  logic hclk, mode, spd, cs_n, rd_n, wr_n, wnr, as_n;
  logic [7:0] addr, wdat, rdat, live, evt, pins;
  // Host view of the data bus: a released bus shows the inverse of the last byte,
  // so a read that the device never drives cannot pass on a stale value
  logic [7:0] bus_view;
  assign bus_view = oe_n ? ~rdat : rdat;
  logic [1:0] cnt_ev;
  logic [3:0] rcnt = 4'h0;
  int error_cnt = 0, n_checks = 0, cyc = 0, hi_cyc = 0;
  hrps_row_t rows [7] = '{
    '{2'd0, OFS_GENERAL, 8'h7e, 8'h7e & GENERAL_MASK, 8'h00, 1'b0},
    '{2'd1, OFS_OUT_PIN, 8'ha5, 8'ha5, 8'ha5, 1'b0},
    '{2'd0, OFS_PART_ID, 8'hff, ID_CODE, 8'ha5, 1'b0},
    '{2'd1, 8'h07, 8'h11, RD_UNMAPPED, 8'ha5, 1'b0},
    '{2'd2, OFS_OUT_PIN, 8'h3c, 8'h3c, 8'h3c, 1'b0},
    '{2'd2, OFS_GENERAL, 8'h04, 8'h04, 8'h3c, 1'b1},
    '{2'd1, OFS_GENERAL, 8'h00, 8'h00, 8'h96, 1'b1}};
  hrps_host_model hrps_host_model_i (.core_clk_in(clk), .dev_data_in(bus_view),
    .host_clk_out(hclk), .mode_out(mode), .speed_out(spd), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .wnr_out(wnr), .as_n_out(as_n), .addr_out(addr), .data_out(wdat));
  hrps_host_port #(.REF_PERIODS(8), .PART_ID(ID_CODE)) hrps_host_port_i (
    .core_clk_in(clk), .resetn_in(rstn), .host_clk_in(hclk), .port_mode_select_in(mode),
    .access_speed_select_in(spd), .host_chip_select_n_in(cs_n), .host_read_strobe_n_in(rd_n),
    .host_write_strobe_n_in(wr_n), .host_write_not_read_in(wnr), .host_addr_strobe_n_in(as_n),
    .host_addr_in(addr), .host_data_in(wdat), .host_data_out(rdat), .host_data_oe_n_out(oe_n),
    .host_interrupt_n_out(int_n), .irq_request_in(irq), .output_status_pins_out(pins),
    .live_status_in(live), .event_status_in(evt), .count_event_in(cnt_ev),
    .frame_rate_ref_in(ref_clk), .second_pulse_out(sec_out), .second_pulse_in(sec_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Reference of 16 core cycles; held idle until soft reset is done
  always @(negedge clk) begin
    rcnt <= rcnt + 4'h1;
    ref_clk <= ref_on & rcnt[3];
  end
  // Watchdog, and cycles the second pulse stands high
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hi_cyc <= hi_cyc + int'(sec_out === 1'b1);
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    hrps_host_model_i.acc(m, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic [1:0] m, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    hrps_host_model_i.acc(m, 1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Counting events stand high for n cycles, one count each
  task automatic pulse_cnt(input logic [1:0] v, input int n);
    @(negedge clk) cnt_ev = v;
    repeat (n) @(negedge clk);
    cnt_ev = 2'b00;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {rstn, irq, ref_on, sec_in} = 4'b0100;
    live = 8'h96;
    evt = 8'h00;
    cnt_ev = 2'b00;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rd(2'd0, OFS_GENERAL, GENERAL_RESET);
    foreach (rows[i]) begin
      wr(rows[i].m, rows[i].a, rows[i].w);
      rd(rows[i].m, rows[i].a, rows[i].e);
      chk("status pins", rows[i].p, pins);
      chk("irq pin", {7'h00, rows[i].q}, {7'h00, int_n});
    end
    // Live view, sticky event that clears on read, refused write
    @(negedge clk) evt = 8'h21;
    @(negedge clk) evt = 8'h00;
    wr(2'd0, OFS_EVT_STAT, 8'hff);
    rd(2'd0, OFS_LIVE_STAT, 8'h96);
    rd(2'd0, OFS_EVT_STAT, 8'h21);
    rd(2'd0, OFS_EVT_STAT, 8'h00);
    // Low byte first freezes the high byte; counters clear on read
    pulse_cnt(2'b11, 258);
    rd(2'd0, OFS_CNT_BASE, 8'h02);
    // Live high byte moves to 0x02, so the frozen 0x01 is told apart from it
    pulse_cnt(2'b11, 512);
    rd(2'd0, OFS_CNT_BASE + 8'h01, 8'h01);
    rd(2'd1, OFS_CNT_BASE + 8'h02, 8'h02);
    rd(2'd1, OFS_CNT_BASE + 8'h03, 8'h03);
    rd(2'd2, OFS_CNT_BASE, 8'h00);
    rd(2'd2, OFS_CNT_BASE + 8'h01, 8'h02);
    // Soft reset, committed on the trailing strobe edge
    wr(2'd1, OFS_GENERAL, 8'h75);
    rd(2'd0, OFS_GENERAL, GENERAL_RESET);
    rd(2'd0, OFS_OUT_PIN, OUT_PIN_RESET);
    // One-second latching with a long capture pulse
    @(negedge clk) {irq, ref_on} = 2'b01;
    wr(2'd0, OFS_GENERAL, 8'h30);
    pulse_cnt(2'b01, 3);
    // Sticky event raised before the capture must show in the snapshot
    @(negedge clk) evt = 8'h42;
    @(negedge clk) evt = 8'h00;
    @(negedge clk) sec_in = 1'b1;
    repeat (3) @(negedge clk);
    pulse_cnt(2'b01, 2);
    sec_in = 1'b0;
    @(negedge clk) live = 8'h0f;
    rd(2'd0, OFS_CNT_BASE, 8'h03);
    rd(2'd0, OFS_CNT_BASE, 8'h03);
    rd(2'd0, OFS_LIVE_STAT, 8'h96);
    rd(2'd0, OFS_EVT_STAT, 8'h42);
    @(negedge clk) sec_in = 1'b1;
    @(negedge clk) sec_in = 1'b0;
    repeat (4) @(negedge clk);
    rd(2'd0, OFS_CNT_BASE, 8'h02);
    rd(2'd0, OFS_LIVE_STAT, 8'h0f);
    rd(2'd0, OFS_EVT_STAT, 8'h00);
    repeat (300) @(negedge clk);
    repeat (20) if (sec_out !== 1'b0) @(negedge clk);
    chk("pulse cycles", 8'h01, {7'h00, hi_cyc > 0 && hi_cyc % 16 == 0});
    test_done();
  end
endmodule
`default_nettype wire
